// *** hdl/ddr2_rpd_pkg.sv ***
`default_nettype none
package ddr2_rpd_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int REFI_NS       = 7800;
	localparam int REFI_CYCLES   = (REFI_NS / CLK_PERIOD_NS < 1) ? 1 : REFI_NS / CLK_PERIOD_NS;
	localparam int ROW_BITS      = 13;
	localparam int BANKS         = 4;
	localparam int ADDR_W        = 4;
	localparam int DATA_W        = 16;

	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_TIMING = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_ROW    = 4'h3;

	localparam int CTRL_FAST_EXIT = 0;
	localparam int CTRL_BURST8    = 1;
	localparam int CTRL_WL_LSB    = 2;
	localparam int CTRL_REINIT    = 7;
	localparam logic [15:0] CTRL_RESET = 16'h0008;

	localparam int TIM_TWR_LSB  = 0;
	localparam int TIM_TRFC_LSB = 4;
	localparam int TIM_TMRD_LSB = 12;
	localparam logic [15:0] TIMING_RESET = 16'h2043;

	localparam int STAT_BANK_LSB  = 0;
	localparam int STAT_STATE_LSB = 4;
	localparam int STAT_LOST      = 7;
	localparam int STAT_BURST     = 8;
	localparam int STAT_DLL       = 9;

	localparam logic [5:0] HALF_BL4 = 6'h02;
	localparam logic [5:0] HALF_BL8 = 6'h04;

	typedef enum logic [2:0] {
		ST_READY   = 3'b000,
		ST_PD_PRE  = 3'b001,
		ST_PD_ACT  = 3'b011,
		ST_SELF    = 3'b010,
		ST_REFRESH = 3'b100,
		ST_LOST    = 3'b110
	} state_type;

	typedef enum logic [3:0] {
		CMD_MRS    = 4'h0,
		CMD_REF    = 4'h1,
		CMD_PRE    = 4'h2,
		CMD_ACT    = 4'h3,
		CMD_WR     = 4'h4,
		CMD_RD     = 4'h5,
		CMD_RSVD   = 4'h6,
		CMD_NOP    = 4'h7,
		CMD_UNSEL  = 4'h8
	} cmd_type;

	typedef struct packed {
		logic       cke;
		logic       odt;
		logic       cs_n;
		logic       ras_n;
		logic       cas_n;
		logic       we_n;
		logic       a10;
		logic [1:0] ba;
	} pin_bundle_type;
endpackage : ddr2_rpd_pkg
`default_nettype wire

// *** hdl/ddr2_refresh_powerdown_control.sv ***
// Added by the designer: the strobed register port and the register offsets.
`default_nettype none
// Operation
// - write with a10 high closes its bank after burst end plus write recovery
// - cs, ras, cas low with we high at a clock edge is auto-refresh
// - refresh uses the internal row counter and leaves all banks idle
// - refresh code with cke low enters self-refresh on the internal timer
// - self-refresh ignores all inputs except cke and gates the clock internally
// - cke low with no-operation or unselect enters power-down, not mid burst
// - idle banks give precharge power-down, dll off; in active power-down dll off unless fast-exit active
// - power-down turns off input buffers except clock, odt and cke
// - cke high with no-operation or unselect leaves power-down
// - a no-operation command never stops an operation already running
// - cs high acts as no-operation, ignoring ras, cas and we
module ddr2_refresh_powerdown_control
	import ddr2_rpd_pkg::*;
#(
	parameter int REFI_CYC = REFI_CYCLES
) (
	input  wire logic                 mclk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 ck_i,
	input  wire pin_bundle_type       pins_i,
	input  wire logic [ADDR_W-1:0]    reg_addr_i,
	input  wire logic [DATA_W-1:0]    reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [DATA_W-1:0]    reg_rdata_o,
	output logic      [BANKS-1:0]     bank_open_o,
	output logic      [ROW_BITS-1:0]  refresh_row_o,
	output logic                      dll_enable_o,
	output logic                      input_buffers_on_o,
	output logic                      clock_gated_o,
	output logic                      contents_lost_o
);
	localparam int SRW = $clog2(REFI_CYC + 1);

	if (REFI_CYC < 1) begin : g_bad_refi
		$error("refresh interval must be at least one cycle");
	end

	function automatic cmd_type decode_cmd(input pin_bundle_type p);
		return p.cs_n ? CMD_UNSEL : cmd_type'({1'b0, p.ras_n, p.cas_n, p.we_n});
	endfunction : decode_cmd

	function automatic logic is_quiet(input cmd_type c);
		return (c == CMD_NOP) || (c == CMD_UNSEL);
	endfunction : is_quiet

	pin_bundle_type         pins_meta;
	pin_bundle_type         pins_sync;
	pin_bundle_type         pins_d;
	logic                   ck_meta;
	logic                   ck_sync;
	logic                   ck_prev;
	logic                   ck_rise;
	logic                   cke_prev;
	state_type              state;
	state_type              next_state;
	cmd_type                cmd;
	logic                   quiet;
	logic                   exec;
	logic                   ref_take;
	logic                   busy;
	logic [BANKS-1:0]       bank_open;
	logic [BANKS-1:0]       ap_fire;
	logic [5:0]             ap_cnt [BANKS];
	logic [5:0]             ap_load;
	logic [5:0]             half_bl;
	logic [5:0]             burst_cnt;
	logic [3:0]             mrs_cnt;
	logic [7:0]             ref_cnt;
	logic [SRW-1:0]         sr_cnt;
	logic                   sr_tick;
	logic [ROW_BITS-1:0]    row;
	logic [15:0]            ctrl;
	logic [15:0]            timing;
	logic                   reinit;
	logic                   lost;
	logic [2:0]             wl;
	logic [3:0]             twr;

	// pins and link clock pass two flops; pins_d holds the value just before a sampled edge
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pins_meta <= '0;
			pins_sync <= '0;
			pins_d    <= '0;
			ck_meta   <= 1'b0;
			ck_sync   <= 1'b0;
			ck_prev   <= 1'b0;
		end else begin
			pins_meta <= pins_i;
			pins_sync <= pins_meta;
			pins_d    <= pins_sync;
			ck_meta   <= ck_i;
			ck_sync   <= ck_meta;
			ck_prev   <= ck_sync;
		end
	end

	assign ck_rise = ck_sync && !ck_prev;
	assign cmd     = decode_cmd(pins_d);
	assign quiet   = is_quiet(cmd);
	assign wl      = ctrl[CTRL_WL_LSB +: 3];
	assign twr     = timing[TIM_TWR_LSB +: 4];
	assign half_bl = ctrl[CTRL_BURST8] ? HALF_BL8 : HALF_BL4;
	assign ap_load = {3'h0, wl} + half_bl + {2'h0, twr};
	assign busy    = (burst_cnt != 6'h00) || (mrs_cnt != 4'h0);
	assign exec    = ck_rise && state == ST_READY && cke_prev && pins_d.cke;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cke_prev <= 1'b0;
		else if (ck_rise)
			cke_prev <= pins_d.cke;
	end

	always_comb begin
		next_state = state;
		ref_take   = 1'b0;
		unique case (state)
			ST_READY: begin
				if (ck_rise && cke_prev && !pins_d.cke) begin
					if (busy)
						next_state = ST_LOST;
					else if (cmd == CMD_REF && bank_open == '0)
						next_state = ST_SELF;
					else if (quiet)
						next_state = (bank_open != '0) ? ST_PD_ACT : ST_PD_PRE;
					else
						next_state = ST_LOST;
				end else if (exec && cmd == CMD_REF) begin
					next_state = ST_REFRESH;
					ref_take   = 1'b1;
				end
			end
			ST_REFRESH: begin
				if (ck_rise && ref_cnt <= 8'h01)
					next_state = pins_d.cke ? ST_READY : ST_PD_PRE;
			end
			ST_PD_PRE, ST_PD_ACT: begin
				if (ck_rise && pins_d.cke && quiet)
					next_state = ST_READY;
			end
			ST_SELF: begin
				if (ck_rise && pins_d.cke)
					next_state = ST_READY;
			end
			ST_LOST: begin
				if (reinit)
					next_state = ST_READY;
			end
			default: next_state = ST_LOST;
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			state <= ST_READY;
		else
			state <= next_state;
	end

	// a no-operation leaves the running burst counting down
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			burst_cnt <= 6'h00;
		else if (state == ST_LOST)
			burst_cnt <= 6'h00;
		else if (exec && cmd == CMD_RD)
			burst_cnt <= {3'h0, wl} + half_bl + 6'h01;
		else if (exec && cmd == CMD_WR)
			burst_cnt <= {3'h0, wl} + half_bl;
		else if (ck_rise && burst_cnt != 6'h00)
			burst_cnt <= burst_cnt - 6'h01;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			mrs_cnt <= 4'h0;
		else if (exec && cmd == CMD_MRS)
			mrs_cnt <= timing[TIM_TMRD_LSB +: 4];
		else if (ck_rise && mrs_cnt != 4'h0)
			mrs_cnt <= mrs_cnt - 4'h1;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			ref_cnt <= 8'h00;
		else if (ref_take)
			ref_cnt <= timing[TIM_TRFC_LSB +: 8];
		else if (ck_rise && ref_cnt != 8'h00)
			ref_cnt <= ref_cnt - 8'h01;
	end

	for (genvar b = 0; b < BANKS; b++) begin : g_ap
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i)
				ap_cnt[b] <= 6'h00;
			else if (state == ST_LOST)
				ap_cnt[b] <= 6'h00;
			else if (exec && cmd == CMD_WR && pins_d.a10 && pins_d.ba == 2'(b))
				ap_cnt[b] <= ap_load;
			else if (ck_rise && ap_cnt[b] != 6'h00)
				ap_cnt[b] <= ap_cnt[b] - 6'h01;
		end
		assign ap_fire[b] = ck_rise && ap_cnt[b] == 6'h01;

		property p_autopre_close;
			@(posedge mclk_i) disable iff (!reset_n_i)
			ap_fire[b] && !(exec && cmd == CMD_ACT && pins_d.ba == 2'(b)) |=> !bank_open[b];
		endproperty
		a_autopre_close: assert property (p_autopre_close) else $error("auto precharge did not close bank");
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			bank_open <= '0;
		else if (ref_take || state == ST_LOST)
			bank_open <= '0;
		else begin
			for (int i = 0; i < BANKS; i++)
				if (ap_fire[i])
					bank_open[i] <= 1'b0;
			if (exec && cmd == CMD_ACT)
				bank_open[pins_d.ba] <= 1'b1;
			if (exec && cmd == CMD_PRE) begin
				if (pins_d.a10)
					bank_open <= '0;
				else
					bank_open[pins_d.ba] <= 1'b0;
			end
		end
	end

	// internal timer runs on the block clock, since the link clock may stop
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			sr_cnt <= '0;
		else if (state != ST_SELF || sr_tick)
			sr_cnt <= '0;
		else
			sr_cnt <= sr_cnt + SRW'(1);
	end
	assign sr_tick = state == ST_SELF && sr_cnt == SRW'(REFI_CYC - 1);

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			row <= '0;
		else if (ref_take || sr_tick)
			row <= row + ROW_BITS'(1);
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			lost <= 1'b0;
		else if (next_state == ST_LOST && state != ST_LOST)
			lost <= 1'b1;
		else if (reinit)
			lost <= 1'b0;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dll_enable_o       <= 1'b1;
			input_buffers_on_o <= 1'b1;
			clock_gated_o      <= 1'b0;
		end else begin
			dll_enable_o       <= !(state == ST_PD_PRE || state == ST_SELF ||
				(state == ST_PD_ACT && !ctrl[CTRL_FAST_EXIT]));
			input_buffers_on_o <= !(state == ST_PD_PRE || state == ST_PD_ACT || state == ST_SELF);
			clock_gated_o      <= state == ST_SELF;
		end
	end

	assign bank_open_o     = bank_open;
	assign refresh_row_o   = row;
	assign contents_lost_o = lost;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl   <= CTRL_RESET;
			timing <= TIMING_RESET;
			reinit <= 1'b0;
		end else begin
			reinit <= reg_wr_i && reg_addr_i == ADDR_CTRL && reg_wdata_i[CTRL_REINIT];
			if (reg_wr_i && reg_addr_i == ADDR_CTRL)
				ctrl <= {8'h00, 3'h0, reg_wdata_i[4:0]};
			if (reg_wr_i && reg_addr_i == ADDR_TIMING)
				timing <= reg_wdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			reg_rdata_o <= '0;
		else if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_CTRL:   reg_rdata_o <= ctrl;
				ADDR_TIMING: reg_rdata_o <= timing;
				ADDR_STATUS: reg_rdata_o <= {6'h00, dll_enable_o, burst_cnt != 6'h00, lost, state, bank_open};
				ADDR_ROW:    reg_rdata_o <= {3'h0, row};
				default:     reg_rdata_o <= '0;
			endcase
		end
	end

	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	property p_ref_decode;
		exec && cmd == CMD_REF |=> state == ST_REFRESH && row == $past(row) + ROW_BITS'(1) && bank_open == '0;
	endproperty
	a_ref_decode: assert property (p_ref_decode) else $error("refresh not decoded");

	property p_ref_idle;
		state == ST_REFRESH && $past(state) == ST_REFRESH |-> bank_open == '0 && row == $past(row);
	endproperty
	a_ref_idle: assert property (p_ref_idle) else $error("bank open during refresh");

	property p_self_entry;
		ck_rise && state == ST_READY && cke_prev && !pins_d.cke && cmd == CMD_REF && !busy && bank_open == '0
			|=> state == ST_SELF ##1 clock_gated_o && !dll_enable_o;
	endproperty
	a_self_entry: assert property (p_self_entry) else $error("self refresh not entered");

	property p_self_hold;
		state == ST_SELF && !(ck_rise && pins_d.cke) |=> state == ST_SELF;
	endproperty
	a_self_hold: assert property (p_self_hold) else $error("self refresh left without cke");

	property p_pd_entry;
		ck_rise && state == ST_READY && cke_prev && !pins_d.cke && quiet && !busy
			|=> state == ($past(bank_open) != '0 ? ST_PD_ACT : ST_PD_PRE) ##1 !input_buffers_on_o;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

	property p_dll_off;
		state == ST_PD_PRE ##1 state == ST_PD_PRE |-> !dll_enable_o;
	endproperty
	a_dll_off: assert property (p_dll_off) else $error("dll on in precharge power-down");

	property p_pd_exit;
		ck_rise && (state == ST_PD_PRE || state == ST_PD_ACT) && pins_d.cke && quiet
			|=> state == ST_READY ##1 input_buffers_on_o;
	endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("power-down not exited");

	property p_nop_burst;
		exec && cmd == CMD_NOP && burst_cnt > 6'h01 |=> burst_cnt == $past(burst_cnt) - 6'h01;
	endproperty
	a_nop_burst: assert property (p_nop_burst) else $error("nop disturbed burst");

	property p_unsel;
		exec && pins_d.cs_n |=> state == ST_READY && bank_open == $past(bank_open & ~ap_fire);
	endproperty
	a_unsel: assert property (p_unsel) else $error("unselect acted as a command");
endmodule : ddr2_refresh_powerdown_control
`default_nettype wire

// *** test/ddr2_ctl_model.sv ***
`default_nettype none
module ddr2_ctl_model
	import ddr2_rpd_pkg::*;
(
	output var logic           ck_o,
	output var pin_bundle_type pins_o
);
	timeunit 1ns;
	timeprecision 100ps;

	pin_bundle_type queued;
	logic           pending;

	// free-running clock, kept stable and never changed in rate
	initial begin
		ck_o = 1'b0;
		forever #100 ck_o = ~ck_o;
	end

	initial begin
		pending = 1'b0;
		pins_o  = {2'b00, 4'b1111, 3'b000};
	end

	// between commands show an unselect that keeps cke; termination stays off
	always @(negedge ck_o) begin
		pins_o  <= (pending === 1'b1) ? queued : {pins_o.cke === 1'b1, 1'b0, 4'b1111, 3'b000};
		pending <= 1'b0;
	end

	// one command a ck edge, launched half a period ahead of the rise
	task automatic issue(input logic cke, input logic [3:0] code, input logic a10, input logic [1:0] ba);
		queued  = {cke, 1'b0, code, a10, ba};
		pending = 1'b1;
		@(negedge ck_o);
		@(posedge ck_o);
	endtask : issue
endmodule : ddr2_ctl_model
`default_nettype wire

// *** test/tb_top.sv ***
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ddr2_rpd_pkg::*;

	localparam logic [3:0] C_NOP = 4'b0111;
	localparam logic [3:0] C_REF = 4'b0001;
	localparam logic [3:0] C_ACT = 4'b0011;
	localparam logic [3:0] C_WR  = 4'b0100;
	localparam logic [3:0] C_PRE = 4'b0010;
	localparam logic [3:0] C_UNS = 4'b1000;
	localparam logic [3:0] C_RD  = 4'b0101;
	localparam logic [3:0] C_MRS = 4'b0000;

	logic                mclk;
	logic                reset_n;
	logic                ck;
	pin_bundle_type      pins;
	logic [ADDR_W-1:0]   reg_addr;
	logic [DATA_W-1:0]   reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [DATA_W-1:0]   reg_rdata;
	logic [BANKS-1:0]    bank_open;
	logic [ROW_BITS-1:0] refresh_row;
	logic                dll_en;
	logic                buf_on;
	logic                gated;
	logic                lost;
	int                  miscompares;
	int                  tests_run;
	int                  cycles;
	logic [15:0]         d;
	logic [15:0]         r1;

	ddr2_refresh_powerdown_control #(.REFI_CYC(8)) dut (
		.mclk_i(mclk), .reset_n_i(reset_n), .ck_i(ck), .pins_i(pins),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .bank_open_o(bank_open), .refresh_row_o(refresh_row),
		.dll_enable_o(dll_en), .input_buffers_on_o(buf_on), .clock_gated_o(gated),
		.contents_lost_o(lost)
	);

	ddr2_ctl_model ctl (.ck_o(ck), .pins_o(pins));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : reg_read

	// wait n ck rises, then long enough for the block to act on the last one
	task automatic ck_edges(input int n);
		repeat (n) @(posedge ck);
		repeat (6) @(posedge mclk);
		#1;
	endtask : ck_edges

	task automatic cmd(input logic cke, input logic [3:0] c, input logic a10 = 1'b0, input logic [1:0] ba = 2'b00);
		ctl.issue(cke, c, a10, ba);
		ck_edges(0);
	endtask : cmd

	task automatic state_is(input logic [2:0] s);
		reg_read(ADDR_STATUS, d);
		chk({13'h0, d[6:4]}, {13'h0, s});
	endtask : state_is

	initial begin
		miscompares = 0;
		tests_run   = 0;
		cycles      = 0;
		reset_n     = 1'b0;
		reg_addr    = 4'h0;
		reg_wdata   = 16'h0000;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		reg_read(ADDR_CTRL, d);
		chk(d, 16'h0008);
		reg_read(ADDR_TIMING, d);
		chk(d, 16'h2043);
		reg_read(ADDR_STATUS, d);
		chk(d, 16'h0200);
		reg_read(4'h9, d);
		chk(d, 16'h0000);
		chk({dll_en, buf_on, gated, lost}, 16'h000c);
		// write closing: wl 2 + half burst 2 + recovery 3 = 7 edges
		cmd(1'b1, C_NOP);
		cmd(1'b1, C_ACT, 1'b0, 2'b01);
		chk(bank_open, 16'h0002);
		cmd(1'b1, C_WR, 1'b1, 2'b01);
		cmd(1'b1, C_NOP);
		cmd(1'b1, C_UNS);
		ck_edges(2);
		chk(bank_open, 16'h0002);
		ck_edges(1);
		chk(bank_open, 16'h0000);
		// auto-refresh takes the internal row and ends with banks idle
		reg_read(ADDR_ROW, r1);
		cmd(1'b1, C_REF, 1'b1, 2'b11);
		state_is(3'h4);
		reg_read(ADDR_ROW, d);
		chk(d, r1 + 16'h0001);
		chk({3'h0, refresh_row}, r1 + 16'h0001);
		ck_edges(5);
		state_is(3'h0);
		chk(bank_open, 16'h0000);
		// precharge power-down
		cmd(1'b0, C_NOP);
		state_is(3'h1);
		chk({dll_en, buf_on}, 16'h0000);
		cmd(1'b1, C_NOP);
		state_is(3'h0);
		chk({dll_en, buf_on}, 16'h0003);
		// active power-down, slow then fast exit
		cmd(1'b1, C_ACT, 1'b0, 2'b00);
		cmd(1'b0, C_NOP);
		state_is(3'h3);
		chk(dll_en, 1'b0);
		cmd(1'b1, C_NOP);
		reg_write(ADDR_CTRL, 16'h0009);
		cmd(1'b0, C_NOP);
		state_is(3'h3);
		chk({dll_en, buf_on}, 16'h0002);
		cmd(1'b1, C_NOP);
		state_is(3'h0);
		cmd(1'b1, C_PRE, 1'b1, 2'b00);
		chk(bank_open, 16'h0000);
		// self-refresh on the internal timer, other inputs ignored
		cmd(1'b0, C_REF);
		state_is(3'h2);
		chk(gated, 1'b1);
		reg_read(ADDR_ROW, r1);
		repeat (78) @(posedge mclk);
		reg_read(ADDR_ROW, d);
		chk(d - r1, 16'h000a);
		cmd(1'b0, C_ACT, 1'b0, 2'b11);
		chk(bank_open, 16'h0000);
		cmd(1'b1, C_NOP);
		state_is(3'h0);
		chk(gated, 1'b0);
		// burst of 8: closing waits wl 2 + half burst 4 + recovery 3 = 9 edges
		reg_write(ADDR_CTRL, 16'h000a);
		cmd(1'b1, C_ACT, 1'b0, 2'b11);
		cmd(1'b1, C_WR, 1'b1, 2'b11);
		ck_edges(8);
		chk(bank_open, 16'h0008);
		ck_edges(1);
		chk(bank_open, 16'h0000);
		// a read burst of 8 keeps the burst flag for wl + 1 + 4 edges
		cmd(1'b1, C_ACT, 1'b0, 2'b11);
		cmd(1'b1, C_RD, 1'b0, 2'b11);
		reg_read(ADDR_STATUS, d);
		chk({11'h000, d[8], d[3:0]}, 16'h0018);
		ck_edges(7);
		reg_read(ADDR_STATUS, d);
		chk({11'h000, d[8], d[3:0]}, 16'h0008);
		cmd(1'b1, C_PRE, 1'b1, 2'b00);
		reg_write(ADDR_CTRL, 16'h0008);
		chk(bank_open, 16'h0000);
		// cke dropped while a write burst runs
		cmd(1'b1, C_ACT, 1'b0, 2'b10);
		cmd(1'b1, C_WR, 1'b0, 2'b10);
		cmd(1'b0, C_NOP);
		state_is(3'h6);
		chk({lost, bank_open}, 16'h0010);
		cmd(1'b1, C_NOP);
		reg_write(ADDR_CTRL, 16'h0088);
		repeat (2) @(posedge mclk);
		state_is(3'h0);
		chk(lost, 1'b0);
		// cke dropped inside the mode-register time
		cmd(1'b1, C_MRS);
		cmd(1'b0, C_NOP);
		state_is(3'h6);
		chk(lost, 1'b1);
		cmd(1'b1, C_NOP);
		reg_write(ADDR_CTRL, 16'h0088);
		repeat (2) @(posedge mclk);
		state_is(3'h0);
		chk(lost, 1'b0);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
